// file: pressure_readout_pkg.sv
// constants, types and the state encoding of the pressure and temperature
// readout; assumes a 50 MHz core clock and a free-running link clock.
// Overview of operation
// RULE_01: once addressed for reading, the device sends two pressure bytes and then two temperature bytes.
// RULE_02: the first byte carries the high part of the 15-bit pressure code and the second byte the low part.
// RULE_03: the third byte carries the high part of the 15-bit temperature code and the fourth the low part.
// RULE_04: a fresh pressure and temperature pair is taken every 2.2 ms and reads return the newest pair.
// RULE_05: after the fourth byte, pressure and temperature keep alternating byte after byte until STOP.
// RULE_06: the pressure code sits at 3277 at the bottom of the range and spans 26214 codes.
// RULE_07: the pressure code sits at 29491 at the top of the range.
// RULE_08: the temperature code runs from 8192 at the bottom to 24576 at the top.
// RULE_09: only the 7-bit address 0x78 selects the device.
// RULE_10: the device only transmits and answers only when the direction bit asks for a read.
// RULE_11: the master acknowledges each byte to get more and ends with no-acknowledge and STOP.
// RULE_12: the unused top bit of every high byte is sent as zero.
// RULE_13: each four-byte group takes both values from one and the same sample period.
package pressure_readout_pkg;
  localparam int CODE_W = 15;
  localparam int CNT_W = 24;
  localparam logic [6:0] SLAVE_ADDR = 7'h78;
  localparam logic [14:0] PRESS_MIN_CODE = 15'h0CCD;
  localparam logic [14:0] full_scale_code_span = 15'h6666;
  localparam logic [14:0] PRESS_MAX_CODE = PRESS_MIN_CODE + full_scale_code_span;
  localparam logic [14:0] TEMP_MIN_CODE = 15'h2000;
  localparam logic [14:0] TEMP_MAX_CODE = 15'h6000;
  localparam real SAMPLE_PERIOD_MS = 2.2;
  localparam real REF_CLK_MHZ = 50.0;
  localparam int SAMPLE_CYCLES = int'(SAMPLE_PERIOD_MS * 1000.0 * REF_CLK_MHZ);
  localparam logic [1:0] BYTE_PRESS_HI = 2'h0;
  localparam logic [1:0] BYTE_PRESS_LO = 2'h1;
  localparam logic [1:0] BYTE_TEMP_HI = 2'h2;
  localparam logic [1:0] BYTE_TEMP_LO = 2'h3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic SDA_OE_RST = 1'b0;
  localparam logic [CODE_W-1:0] CODE_RST = 15'h0000;

  typedef enum logic [4:0] {
    LS_IDLE = 5'h01,
    LS_ADDR = 5'h02,
    LS_ADDR_ACK = 5'h04,
    LS_TX = 5'h08,
    LS_RX_ACK = 5'h10
  } link_state_t;
endpackage

// file: bit_sync2.sv
// two-stage synchroniser for a vector of independent levels
// assumes each bit is a slow level or a toggle, never a coherent word
`timescale 1ns/1ns
`default_nettype none
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] out_ff;
  } sync_t;

  sync_t state_ff;
  sync_t nxt_state;

  always_comb begin
    nxt_state.meta_ff = i_d;
    nxt_state.out_ff = state_ff.meta_ff;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_q = state_ff.out_ff;
endmodule // bit_sync2
`default_nettype wire

// file: pressure_temp_i2c_readout.sv
// read-only i2c slave transmitter for pressure and temperature codes
// assumes sample codes come from core-clock logic, pins are asynchronous and
// the link clock runs free well above the bus clock (12.5 MHz for 400 kHz)
`timescale 1ns/1ns
`default_nettype none
module pressure_temp_i2c_readout
  import pressure_readout_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic [CODE_W-1:0] i_press_code,
  input wire logic [CODE_W-1:0] i_temp_code,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_read_active
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic req;
    logic [CODE_W-1:0] held_p;
    logic [CODE_W-1:0] held_t;
  } ref_state_t;

  typedef struct packed {
    link_state_t state;
    logic scl_d;
    logic sda_d;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic [1:0] idx;
    logic seen;
    logic [CODE_W-1:0] snap_p;
    logic [CODE_W-1:0] snap_t;
    logic [CODE_W-1:0] grp_p;
    logic [CODE_W-1:0] grp_t;
    logic sda_oe;
    logic sda_o;
    logic active;
  } link_st_t;

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYC - 1);

  logic ref_rst_n;
  logic link_rst_n;
  logic ack_s;
  logic req_s;
  logic scl_s;
  logic sda_s;
  ref_state_t ref_ff;
  ref_state_t nxt_ref;
  link_st_t link_ff;
  link_st_t nxt_link;

  function automatic logic [CODE_W-1:0] clamp(input logic [CODE_W-1:0] v,
                                              input logic [CODE_W-1:0] lo,
                                              input logic [CODE_W-1:0] hi);
    logic [CODE_W-1:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // reset is released per domain; assertion stays asynchronous
  bit_sync2 #(.WIDTH(1)) u_ref_rst (
    .i_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(ref_rst_n)
  );

  bit_sync2 #(.WIDTH(1)) u_link_rst (
    .i_clk(i_link_clk),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(link_rst_n)
  );

  bit_sync2 #(.WIDTH(1)) u_ack_sync (
    .i_clk(i_ref_clk),
    .i_rst_n(ref_rst_n),
    .i_d(link_ff.seen),
    .o_q(ack_s)
  );

  bit_sync2 #(.WIDTH(3)) u_link_sync (
    .i_clk(i_link_clk),
    .i_rst_n(link_rst_n),
    .i_d({ref_ff.req, i_scl, i_sda}),
    .o_q({req_s, scl_s, sda_s})
  );

  // sample side: one pair per period, handed over by a toggle handshake
  always_comb begin
    nxt_ref = ref_ff;
    nxt_ref.cnt = ref_ff.cnt + 1'b1;
    if (ref_ff.cnt >= CNT_LAST) begin
      nxt_ref.cnt = '0;
      // a pair still in flight is kept; the next period catches up
      if (ack_s == ref_ff.req) begin
        nxt_ref.held_p = clamp(i_press_code, PRESS_MIN_CODE,
                               PRESS_MAX_CODE); // RULE_06 RULE_07
        nxt_ref.held_t = clamp(i_temp_code, TEMP_MIN_CODE,
                               TEMP_MAX_CODE); // RULE_08
        nxt_ref.req = ~ref_ff.req; // RULE_04
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge ref_rst_n) begin
    if (!ref_rst_n) begin
      ref_ff <= '0;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  // link side
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic do_load;
  logic [CODE_W-1:0] src_p;
  logic [CODE_W-1:0] src_t;
  logic [7:0] tx_byte;

  always_comb begin
    scl_rise = scl_s & ~link_ff.scl_d;
    scl_fall = ~scl_s & link_ff.scl_d;
    bus_start = scl_s & link_ff.scl_d & link_ff.sda_d & ~sda_s;
    bus_stop = scl_s & link_ff.scl_d & ~link_ff.sda_d & sda_s;
    // a new group freezes the newest pair, later bytes reuse it
    src_p = (link_ff.idx == BYTE_PRESS_HI) ? link_ff.snap_p
                                            : link_ff.grp_p; // RULE_13
    src_t = (link_ff.idx == BYTE_PRESS_HI) ? link_ff.snap_t
                                            : link_ff.grp_t; // RULE_13
    case (link_ff.idx)
      BYTE_PRESS_HI: tx_byte = {1'b0, src_p[14:8]}; // RULE_02 RULE_12
      BYTE_PRESS_LO: tx_byte = src_p[7:0]; // RULE_02
      BYTE_TEMP_HI: tx_byte = {1'b0, src_t[14:8]}; // RULE_03 RULE_12
      BYTE_TEMP_LO: tx_byte = src_t[7:0]; // RULE_03
      default: tx_byte = 8'h00;
    endcase
  end

  always_comb begin
    nxt_link = link_ff;
    do_load = 1'b0;
    nxt_link.scl_d = scl_s;
    nxt_link.sda_d = sda_s;
    nxt_link.sda_o = 1'b0;
    // held words are stable while the toggle is unanswered
    if (req_s != link_ff.seen) begin
      nxt_link.snap_p = ref_ff.held_p; // RULE_04
      nxt_link.snap_t = ref_ff.held_t; // RULE_04
      nxt_link.seen = req_s;
    end
    case (link_ff.state)
      LS_IDLE: begin
        nxt_link.sda_oe = 1'b0;
      end
      LS_ADDR: begin
        if (scl_rise) begin
          nxt_link.shift = {link_ff.shift[6:0], sda_s};
          nxt_link.bitcnt = link_ff.bitcnt + 1'b1;
          if (link_ff.bitcnt == LAST_BIT) begin
            if ((link_ff.shift[6:0] == SLAVE_ADDR) && sda_s) begin // RULE_09 RULE_10
              nxt_link.state = LS_ADDR_ACK;
            end else begin
              nxt_link.state = LS_IDLE; // RULE_10
            end
          end
        end
      end
      LS_ADDR_ACK: begin
        if (scl_fall) begin
          if (!link_ff.sda_oe) begin
            nxt_link.sda_oe = 1'b1;
          end else begin
            nxt_link.idx = BYTE_PRESS_HI;
            do_load = 1'b1; // RULE_01
          end
        end
      end
      LS_TX: begin
        if (scl_fall) begin
          if (link_ff.bitcnt == LAST_BIT) begin
            nxt_link.sda_oe = 1'b0;
            nxt_link.bitcnt = 3'h0;
            nxt_link.state = LS_RX_ACK;
          end else begin
            nxt_link.shift = {link_ff.shift[6:0], 1'b0};
            nxt_link.sda_oe = ~link_ff.shift[6];
            nxt_link.bitcnt = link_ff.bitcnt + 1'b1;
          end
        end
      end
      LS_RX_ACK: begin
        if (scl_rise && sda_s) begin
          nxt_link.state = LS_IDLE; // RULE_11
        end else if (scl_fall) begin
          do_load = 1'b1; // RULE_05
        end
      end
      default: begin
        nxt_link.state = LS_IDLE;
        nxt_link.sda_oe = 1'b0;
      end
    endcase
    if (do_load) begin
      nxt_link.shift = tx_byte;
      nxt_link.sda_oe = ~tx_byte[7];
      nxt_link.bitcnt = 3'h0;
      nxt_link.state = LS_TX;
      // index wraps so the stream keeps alternating
      nxt_link.idx = nxt_link.idx + 1'b1; // RULE_05
      if (nxt_link.idx == BYTE_PRESS_LO) begin
        nxt_link.grp_p = src_p; // RULE_13
        nxt_link.grp_t = src_t; // RULE_13
      end
    end
    // start and stop override any byte in progress
    if (bus_start) begin
      nxt_link.state = LS_ADDR;
      // a cut stream must not leave the next read starting mid-group
      nxt_link.idx = BYTE_PRESS_HI; // RULE_01
      nxt_link.bitcnt = 3'h0;
      nxt_link.sda_oe = 1'b0;
    end else if (bus_stop) begin
      nxt_link.state = LS_IDLE; // RULE_05
      nxt_link.sda_oe = 1'b0;
    end
    nxt_link.active = (nxt_link.state == LS_ADDR_ACK) ||
                      (nxt_link.state == LS_TX) ||
                      (nxt_link.state == LS_RX_ACK);
  end

  always_ff @(posedge i_link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_ff.state <= LS_IDLE;
      link_ff.scl_d <= 1'b0;
      link_ff.sda_d <= 1'b0;
      link_ff.shift <= 8'h00;
      link_ff.bitcnt <= 3'h0;
      link_ff.idx <= BYTE_PRESS_HI;
      link_ff.seen <= 1'b0;
      link_ff.snap_p <= CODE_RST;
      link_ff.snap_t <= CODE_RST;
      link_ff.grp_p <= CODE_RST;
      link_ff.grp_t <= CODE_RST;
      link_ff.sda_oe <= SDA_OE_RST;
      link_ff.sda_o <= 1'b0;
      link_ff.active <= 1'b0;
    end else begin
      link_ff <= nxt_link;
    end
  end

  assign o_sda_o = link_ff.sda_o;
  assign o_sda_oe = link_ff.sda_oe;
  assign o_read_active = link_ff.active;
endmodule // pressure_temp_i2c_readout
`default_nettype wire

// file: i2c_host_model.sv
// i2c host model: drives the clock, pulls data low, samples the wire
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  output logic o_scl,
  output logic o_pull,
  input wire logic i_sda
);
  localparam int HALF = 800;
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  // data moves only while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    o_pull = ~b;
    #(HALF/2);
    o_scl = 1'b1;
    #(HALF/2);
    s = i_sda;
    #(HALF/2);
    o_scl = 1'b0;
    #(HALF/2);
  endtask
  task automatic xfer(input logic [7:0] adr, input int n, output logic ack,
                      output logic [7:0] d [6]);
    logic s;
    o_pull = 1'b1;
    #HALF;
    o_scl = 1'b0;
    #(HALF/2);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(adr[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        clk_bit(1'b1, d[k][i]);
      end
      clk_bit(k == n - 1, s);
    end
    o_pull = 1'b1;
    #(HALF/2);
    o_scl = 1'b1;
    #(HALF/2);
    o_pull = 1'b0;
    #HALF;
  endtask
endmodule // i2c_host_model
`default_nettype wire

// file: pressure_temp_i2c_readout_checker.sv
// link-side checks for the readout, bound to its top module
// assumes i_sda carries the resolved wire level
`timescale 1ns/1ns
`default_nettype none
module pressure_temp_i2c_readout_checker
  import pressure_readout_pkg::*;
#(
  parameter int SAMPLE_CYC = 200
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic [CODE_W-1:0] i_press_code,
  input wire logic [CODE_W-1:0] i_temp_code,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_read_active
);
  default clocking @(posedge i_link_clk); endclocking
  default disable iff (!i_rst_n);
  a_drive_low: assert property (o_sda_o == 1'b0)
    else $error("data drive level not low");
  a_change_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed with clock high");
  a_hold_high: assert property
    (i_scl && $past(i_scl) && $past(i_scl, 2) |-> $stable(o_sda_oe))
    else $error("data moved in clock high phase");
  a_drive_active: assert property
    ($rose(o_sda_oe) |-> ##[0:2] o_read_active)
    else $error("data driven outside a read");
  a_start_ends: assert property
    (i_scl && $past(i_scl) && $fell(i_sda) |-> ##[2:6] !o_read_active)
    else $error("start did not end the read");
  a_stop_ends: assert property
    (i_scl && $past(i_scl) && $rose(i_sda) |-> ##[2:6] !o_read_active)
    else $error("stop did not end the read");
  a_ack_high: assert property ($rose(o_read_active) |-> i_scl)
    else $error("read began outside the direction bit clock");
  a_end_free: assert property ($fell(o_read_active) |-> !o_sda_oe)
    else $error("data held after read end");
endmodule // pressure_temp_i2c_readout_checker
bind pressure_temp_i2c_readout pressure_temp_i2c_readout_checker
  #(.SAMPLE_CYC(SAMPLE_CYC)) chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk),
  .i_press_code(i_press_code), .i_temp_code(i_temp_code),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_read_active(o_read_active));
`default_nettype wire

// file: pressure_temp_i2c_readout_tb.sv
// self-checking bench for the pressure and temperature readout
// assumes the host model and a sample period shortened to 200 cycles
`timescale 1ns/1ns
`default_nettype none
module pressure_temp_i2c_readout_tb;
  import pressure_readout_pkg::*;
  logic ref_clk, link_clk, rst_n, scl, pull, sda_oe, sda_o, act, ack;
  logic [CODE_W-1:0] press, temp;
  logic [7:0] got [6];
  wire sda;
  int failures, checked;
  // a released wire floats high through the pull-up
  assign sda = ~(sda_oe | pull);
  pressure_temp_i2c_readout #(.SAMPLE_CYC(200)) dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
    .i_press_code(press), .i_temp_code(temp), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_read_active(act));
  i2c_host_model host (.o_scl(scl), .o_pull(pull), .i_sda(sda));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // odd phase keeps link edges off host pin changes
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // two periods so a fresh pair is surely handed over
  task automatic settle(input logic [14:0] p, input logic [14:0] t);
    @(negedge ref_clk);
    press = p;
    temp = t;
    repeat (420) @(negedge ref_clk);
  endtask
  task automatic read_check(input logic [14:0] p, input logic [14:0] t);
    logic [7:0] exp [4];
    exp = '{{1'b0, p[14:8]}, p[7:0], {1'b0, t[14:8]}, t[7:0]};
    host.xfer(8'hF1, 6, ack, got);
    cmp8("address ack", 8'h01, {7'h00, ack});
    cmp8("read active", 8'h00, {7'h00, act});
    for (int k = 0; k < 6; k++) begin
      cmp8("byte", exp[k % 4], got[k]);
    end
  endtask
  task automatic test_plain();
    logic [7:0] exp [4];
    settle(15'h1234, 15'h3000);
    read_check(15'h1234, 15'h3000);
    read_check(15'h1234, 15'h3000);
    // a new pair lands in mid-group and must wait for the next group
    exp = '{8'h12, 8'h34, 8'h30, 8'h00};
    fork
      host.xfer(8'hF1, 4, ack, got);
      begin
        repeat (1000) @(negedge ref_clk);
        press = 15'h2345;
        temp = 15'h3456;
      end
    join
    cmp8("group ack", 8'h01, {7'h00, ack});
    for (int k = 0; k < 4; k++) begin
      cmp8("group byte", exp[k], got[k]);
    end
    $display("test plain done");
  endtask
  // codes beyond the range come out at its ends
  task automatic test_limits();
    settle(15'h0000, 15'h7FFF);
    read_check(15'h0CCD, 15'h6000);
    settle(15'h7FFF, 15'h0000);
    read_check(15'h7333, 15'h2000);
    $display("test limits done");
  endtask
  task automatic test_refuse();
    host.xfer(8'hF3, 0, ack, got);
    cmp8("foreign ack", 8'h00, {7'h00, ack});
    host.xfer(8'hF0, 0, ack, got);
    cmp8("write ack", 8'h00, {7'h00, ack});
    read_check(15'h7333, 15'h2000);
    $display("test refuse done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    failures = 0;
    checked = 0;
    rst_n = 1'b0;
    press = 15'h1234;
    temp = 15'h3000;
    repeat (2) @(posedge link_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    test_plain();
    test_limits();
    test_refuse();
    test_done();
  end
  initial begin
    #1000000;
    failures++;
    test_done();
  end
endmodule // pressure_temp_i2c_readout_tb
`default_nettype wire
